// File: src/fpb_pkg.sv
package fpb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h00;
  localparam logic [7:0] ADDR_PICTURE_FRAME_SELECT = 8'h01;
  localparam logic [7:0] ADDR_PLAYBACK_LOOP_FRAME_COUNT = 8'h02;
  localparam logic [7:0] ADDR_PLAYBACK_FRAME_DELAY = 8'h03;
  localparam logic [7:0] ADDR_GLOBAL_CURRENT_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_DISPLAY_OPTIONS = 8'h05;
  localparam logic [7:0] ADDR_FRAME_STATE = 8'h07;

  // Writable bits; reserved bits are stored as zero
  localparam logic [7:0] WMASK_CONFIGURATION = 8'hDF;
  localparam logic [7:0] WMASK_PICTURE_FRAME_SELECT = 8'h07;
  localparam logic [7:0] WMASK_PLAYBACK_LOOP_FRAME_COUNT = 8'h77;
  localparam logic [7:0] WMASK_PLAYBACK_FRAME_DELAY = 8'h3F;
  localparam logic [7:0] WMASK_GLOBAL_CURRENT_LEVEL = 8'hFF;
  localparam logic [7:0] WMASK_DISPLAY_OPTIONS = 8'h2F;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SYNC_LSB = 6;
  localparam int MODE_LSB = 3;
  localparam int START_LSB = 0;
  localparam int PICTURE_LSB = 0;
  localparam int LOOP_LSB = 4;
  localparam int FRAMES_LSB = 0;
  localparam int HOLD_LSB = 0;
  localparam int SHARED_BIT = 5;
  localparam int BLINK_EN_BIT = 3;
  localparam int BLINK_PER_LSB = 0;
  localparam int DONE_BIT = 4;
  localparam int CUR_LSB = 0;

  // Sync role and display mode codes
  localparam logic [1:0] SYNC_MASTER = 2'h1;
  localparam logic [1:0] SYNC_SLAVE = 2'h2;
  localparam logic [1:0] MODE_PICTURE = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;

  // Zero codes standing for full counts
  localparam logic [6:0] HOLD_ZERO_UNITS = 7'h40;
  localparam logic [3:0] FRAMES_ZERO_COUNT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int FRAME_UNIT_MS = 11;
  localparam int BLINK_UNIT_MS = 270;
  localparam int FRAME_UNIT_CYCLES = FRAME_UNIT_MS * 1000 * CLK_MHZ;
  localparam int BLINK_HALF_CYCLES = (BLINK_UNIT_MS * 1000 * CLK_MHZ) / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Playback sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PLAY = 3'b010,
    ST_DONE = 3'b100
  } play_state_e;

endpackage

// File: src/tick_if.sv
`timescale 1ns/1ps
// Timebase hand-off between the register bank and its tick generator
interface tick_if;
  logic use_ext; // Slave role: count master clock edges
  logic ext_edge; // One change seen on the sync pin
  logic unit_tick; // One frame-delay unit elapsed
  logic half_blink_tick; // Half a blink unit elapsed

  modport gen (
    input use_ext,
    input ext_edge,
    output unit_tick,
    output half_blink_tick
  );

  modport user (
    output use_ext,
    output ext_edge,
    input unit_tick,
    input half_blink_tick
  );
endinterface

// File: src/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned UNIT_CYCLES = 2750000,
  parameter int unsigned BLINK_CYCLES = 33750000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  tick_if.gen tk
);
  import fpb_pkg::*;

  logic [31:0] unit_cnt_reg; // Cycles into the current unit
  logic [31:0] unit_cnt_next;
  logic [31:0] blink_cnt_reg; // Cycles into the current half blink unit
  logic [31:0] blink_cnt_next;
  logic unit_tick_reg;
  logic unit_tick_next;
  logic blink_tick_reg;
  logic blink_tick_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next counts; in slave role the master clock replaces the divider
  always_comb begin
    unit_cnt_next = unit_cnt_reg;
    unit_tick_next = 1'b0;
    blink_cnt_next = blink_cnt_reg + 32'h1;
    blink_tick_next = 1'b0;
    if (tk.use_ext) begin
      unit_cnt_next = 32'h0;
      unit_tick_next = tk.ext_edge;
    end else if (unit_cnt_reg >= UNIT_CYCLES - 1) begin
      unit_cnt_next = 32'h0;
      unit_tick_next = 1'b1;
    end else begin
      unit_cnt_next = unit_cnt_reg + 32'h1;
    end
    // Blink base stays local; not phase locked across a cascade
    if (blink_cnt_reg >= BLINK_CYCLES - 1) begin
      blink_cnt_next = 32'h0;
      blink_tick_next = 1'b1;
    end
  end

  // Register the counters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_cnt_reg <= 32'h0;
      blink_cnt_reg <= 32'h0;
      unit_tick_reg <= 1'b0;
      blink_tick_reg <= 1'b0;
    end else if (en_i) begin
      unit_cnt_reg <= unit_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      unit_tick_reg <= unit_tick_next;
      blink_tick_reg <= blink_tick_next;
    end
  end

  assign tk.unit_tick = unit_tick_reg;
  assign tk.half_blink_tick = blink_tick_reg;

  // Local divider never exceeds its period
  chk_unit_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    unit_cnt_reg < UNIT_CYCLES) else $error("unit counter ran past period");
endmodule

// File: src/frame_playback_function_regs.sv
`timescale 1ns/1ps
module frame_playback_function_regs #(
  parameter int unsigned FRAME_UNIT_CYCLES = fpb_pkg::FRAME_UNIT_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = fpb_pkg::BLINK_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  output logic [2:0] display_frame_o,
  output logic [2:0] intensity_frame_o,
  output logic [7:0] global_current_o,
  output logic blink_on_o,
  output logic audio_mode_o
);
  import fpb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Hold units for a delay code; zero means the longest hold
  function automatic logic [6:0] hold_units(input logic [5:0] code);
    hold_units = (code == 6'h00) ? HOLD_ZERO_UNITS : {1'b0, code};
  endfunction

  // Frames per loop for a count code; zero means all frames
  function automatic logic [3:0] frames_in_loop(input logic [2:0] code);
    frames_in_loop = (code == 3'h0) ? FRAMES_ZERO_COUNT : {1'b0, code};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tick_if tk ();

  logic [7:0] configuration_reg;
  logic [7:0] configuration_next;
  logic [7:0] picture_frame_select_reg;
  logic [7:0] picture_frame_select_next;
  logic [7:0] playback_loop_frame_count_reg;
  logic [7:0] playback_loop_frame_count_next;
  logic [7:0] playback_frame_delay_reg;
  logic [7:0] playback_frame_delay_next;
  logic [7:0] global_current_level_reg;
  logic [7:0] global_current_level_next;
  logic [7:0] display_options_reg;
  logic [7:0] display_options_next;
  logic [7:0] rdata_reg; // Read answer, held until next read
  logic [7:0] rdata_next;

  play_state_e state_reg;
  play_state_e state_next;
  logic [2:0] cur_reg; // Frame on display, code n is frame n+1
  logic [2:0] cur_next;
  logic [3:0] shown_reg; // Frames shown in the current loop
  logic [3:0] shown_next;
  logic [2:0] loops_reg; // Loops completed
  logic [2:0] loops_next;
  logic [6:0] delay_reg; // Units elapsed on the current frame
  logic [6:0] delay_next;
  logic done_reg; // Movie finished flag
  logic done_next;

  logic [2:0] blink_half_reg; // Half units into the current blink half
  logic [2:0] blink_half_next;
  logic blink_phase_reg;
  logic blink_phase_next;

  logic sync_d_reg; // Previous sync pin level, for edge detect
  logic sync_out_reg;
  logic sync_out_next;
  logic sync_oe_reg;
  logic sync_oe_next;
  logic [2:0] intensity_reg;
  logic [2:0] intensity_next;
  logic [7:0] gcc_out_reg;
  logic blink_on_reg;
  logic blink_on_next;
  logic audio_reg;

  // Field views
  logic [1:0] sync_role;
  logic [1:0] display_mode;
  logic [2:0] start_frame_sel;
  logic [2:0] picture_frame_sel;
  logic [2:0] loop_count_sel;
  logic [2:0] frame_count_sel;
  logic [5:0] frame_hold_time;
  logic shared_intensity;
  logic blink_enable;
  logic [2:0] blink_period;

  // Bus decode and sequencer events
  logic wr_cfg;
  logic rd_state;
  logic advance;
  logic loop_end;
  logic set_done;

  assign sync_role = configuration_reg[SYNC_LSB +: 2];
  assign display_mode = configuration_reg[MODE_LSB +: 2];
  assign start_frame_sel = configuration_reg[START_LSB +: 3];
  assign picture_frame_sel = picture_frame_select_reg[PICTURE_LSB +: 3];
  assign loop_count_sel = playback_loop_frame_count_reg[LOOP_LSB +: 3];
  assign frame_count_sel = playback_loop_frame_count_reg[FRAMES_LSB +: 3];
  assign frame_hold_time = playback_frame_delay_reg[HOLD_LSB +: 6];
  assign shared_intensity = display_options_reg[SHARED_BIT];
  assign blink_enable = display_options_reg[BLINK_EN_BIT];
  assign blink_period = display_options_reg[BLINK_PER_LSB +: 3];

  assign wr_cfg = reg_wr_i && (reg_addr_i == ADDR_CONFIGURATION);
  assign rd_state = reg_rd_i && (reg_addr_i == ADDR_FRAME_STATE);

  ////////////////////////////////////////////////////////////////////////////
  // Timebase; slave role counts changes of the master clock pin
  assign tk.use_ext = (sync_role == SYNC_SLAVE);
  assign tk.ext_edge = sync_i ^ sync_d_reg;

  tick_gen #(
    .UNIT_CYCLES(FRAME_UNIT_CYCLES),
    .BLINK_CYCLES(BLINK_HALF_CYCLES)
  ) u_tick_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file: masked writes, registered reads
  always_comb begin
    configuration_next = configuration_reg;
    picture_frame_select_next = picture_frame_select_reg;
    playback_loop_frame_count_next = playback_loop_frame_count_reg;
    playback_frame_delay_next = playback_frame_delay_reg;
    global_current_level_next = global_current_level_reg;
    display_options_next = display_options_reg;
    rdata_next = rdata_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_CONFIGURATION: configuration_next = reg_wdata_i & WMASK_CONFIGURATION;
        ADDR_PICTURE_FRAME_SELECT: picture_frame_select_next = reg_wdata_i & WMASK_PICTURE_FRAME_SELECT;
        ADDR_PLAYBACK_LOOP_FRAME_COUNT: begin
          playback_loop_frame_count_next = reg_wdata_i & WMASK_PLAYBACK_LOOP_FRAME_COUNT;
        end
        ADDR_PLAYBACK_FRAME_DELAY: playback_frame_delay_next = reg_wdata_i & WMASK_PLAYBACK_FRAME_DELAY;
        ADDR_GLOBAL_CURRENT_LEVEL: global_current_level_next = reg_wdata_i & WMASK_GLOBAL_CURRENT_LEVEL;
        ADDR_DISPLAY_OPTIONS: display_options_next = reg_wdata_i & WMASK_DISPLAY_OPTIONS;
        default: begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CONFIGURATION: rdata_next = configuration_reg;
        ADDR_PICTURE_FRAME_SELECT: rdata_next = picture_frame_select_reg;
        ADDR_PLAYBACK_LOOP_FRAME_COUNT: rdata_next = playback_loop_frame_count_reg;
        ADDR_PLAYBACK_FRAME_DELAY: rdata_next = playback_frame_delay_reg;
        ADDR_GLOBAL_CURRENT_LEVEL: rdata_next = global_current_level_reg;
        ADDR_DISPLAY_OPTIONS: rdata_next = display_options_reg;
        ADDR_FRAME_STATE: begin
          rdata_next = 8'h00;
          rdata_next[DONE_BIT] = done_reg;
          rdata_next[CUR_LSB +: 3] = cur_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      configuration_reg <= RST_REG;
      picture_frame_select_reg <= RST_REG;
      playback_loop_frame_count_reg <= RST_REG;
      playback_frame_delay_reg <= RST_REG;
      global_current_level_reg <= RST_REG;
      display_options_reg <= RST_REG;
      rdata_reg <= RST_REG;
    end else if (en_i) begin
      configuration_reg <= configuration_next;
      picture_frame_select_reg <= picture_frame_select_next;
      playback_loop_frame_count_reg <= playback_loop_frame_count_next;
      playback_frame_delay_reg <= playback_frame_delay_next;
      global_current_level_reg <= global_current_level_next;
      display_options_reg <= display_options_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback sequencer
  // advance once hold units elapse
  assign advance = (state_reg == ST_PLAY) && tk.unit_tick &&
                   ((delay_reg + 7'h01) == hold_units(frame_hold_time));
  // loop ends after its frame count
  assign loop_end = advance && (shown_reg == frames_in_loop(frame_count_sel));
  assign set_done = loop_end && (loop_count_sel != 3'h0) &&
                    (3'(loops_reg + 3'h1) == loop_count_sel);

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    shown_next = shown_reg;
    loops_next = loops_reg;
    delay_next = delay_reg;
    done_next = set_done | (done_reg & ~rd_state);
    if (display_mode == MODE_PICTURE) begin
      state_next = ST_IDLE;
      cur_next = picture_frame_sel;
    end else if (display_mode != MODE_AUTO) begin
      // audio playback lies outside this bank; frame held
      state_next = ST_IDLE;
    end else if (wr_cfg) begin
      // Config rewrite: new fields land only at this edge, so reload next cycle
      state_next = ST_IDLE;
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_PLAY;
      cur_next = start_frame_sel;
      shown_next = 4'h1;
      loops_next = 3'h0;
      delay_next = 7'h00;
    end else if (state_reg == ST_PLAY && tk.unit_tick) begin
      delay_next = advance ? 7'h00 : 7'(delay_reg + 7'h01);
      if (set_done) begin
        state_next = ST_DONE;
        cur_next = 3'(start_frame_sel + frame_count_sel);
      end else if (loop_end) begin
        cur_next = start_frame_sel;
        shown_next = 4'h1;
        loops_next = 3'(loops_reg + 3'h1);
      end else if (advance) begin
        // next frame, eight wraps to one
        cur_next = 3'(cur_reg + 3'h1);
        shown_next = 4'(shown_reg + 4'h1);
      end
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cur_reg <= 3'h0;
      shown_reg <= 4'h1;
      loops_reg <= 3'h0;
      delay_reg <= 7'h00;
      done_reg <= 1'b0;
    end else if (en_i) begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      shown_reg <= shown_next;
      loops_reg <= loops_next;
      delay_reg <= delay_next;
      done_reg <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink phase; period zero leaves outputs steady on
  always_comb begin
    blink_half_next = blink_half_reg;
    blink_phase_next = blink_phase_reg;
    if (!blink_enable || blink_period == 3'h0) begin
      blink_half_next = 3'h0;
      blink_phase_next = 1'b1;
    end else if (tk.half_blink_tick) begin
      if (3'(blink_half_reg + 3'h1) >= blink_period) begin
        blink_half_next = 3'h0;
        blink_phase_next = ~blink_phase_reg;
      end else begin
        blink_half_next = 3'(blink_half_reg + 3'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage, every output from a flop
  always_comb begin
    sync_oe_next = (sync_role == SYNC_MASTER);
    sync_out_next = sync_out_reg;
    if (sync_role == SYNC_MASTER && tk.unit_tick) begin
      sync_out_next = ~sync_out_reg; // One change per unit for the slaves
    end
    intensity_next = shared_intensity ? 3'h0 : cur_next;
    blink_on_next = blink_phase_next;
  end

  // Output flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_half_reg <= 3'h0;
      blink_phase_reg <= 1'b1;
      sync_d_reg <= 1'b0;
      sync_out_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
      intensity_reg <= 3'h0;
      gcc_out_reg <= 8'h00;
      blink_on_reg <= 1'b1;
      audio_reg <= 1'b0;
    end else if (en_i) begin
      blink_half_reg <= blink_half_next;
      blink_phase_reg <= blink_phase_next;
      sync_d_reg <= sync_i;
      sync_out_reg <= sync_out_next;
      sync_oe_reg <= sync_oe_next;
      intensity_reg <= intensity_next;
      gcc_out_reg <= global_current_level_reg;
      blink_on_reg <= blink_on_next;
      audio_reg <= display_mode[1];
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign sync_o = sync_out_reg;
  assign sync_oe_o = sync_oe_reg;
  assign display_frame_o = cur_reg;
  assign intensity_frame_o = intensity_reg;
  assign global_current_o = gcc_out_reg;
  assign blink_on_o = blink_on_reg;
  assign audio_mode_o = audio_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_sync_drive_role: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i |=> (sync_oe_o == ($past(sync_role) == SYNC_MASTER))) else $error("sync drive does not match role");

  chk_picture_frame_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && display_mode == MODE_PICTURE |=> display_frame_o == $past(picture_frame_sel))
    else $error("picture mode shows wrong frame");

  chk_start_frame_load: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && display_mode == MODE_AUTO && state_reg == ST_IDLE && !wr_cfg |=>
    state_reg == ST_PLAY && cur_reg == $past(start_frame_sel)) else $error("playback did not begin at start");

  chk_hold_units_met: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && state_reg == ST_PLAY && !advance && !wr_cfg && display_mode == MODE_AUTO |=>
    cur_reg == $past(cur_reg)) else $error("frame moved before hold elapsed");

  chk_frame_wrap_step: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && advance && !loop_end && !wr_cfg && display_mode == MODE_AUTO |=>
    cur_reg == 3'($past(cur_reg) + 3'h1)) else $error("frame step wrong");

  chk_loop_frames_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_PLAY && !$changed(playback_loop_frame_count_reg) |->
    shown_reg <= frames_in_loop(frame_count_sel)) else $error("loop showed too many frames");

  chk_halt_rest_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && set_done && !wr_cfg |=> state_reg == ST_DONE &&
    cur_reg == 3'($past(start_frame_sel) + $past(frame_count_sel))) else $error("halt frame wrong");

  chk_endless_never_done: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && loop_count_sel == 3'h0 && state_reg == ST_PLAY && !wr_cfg && display_mode == MODE_AUTO |=>
    state_reg == ST_PLAY) else $error("endless playback finished");

  chk_done_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && rd_state && !set_done |=> !done_reg ##0 rdata_reg[DONE_BIT] == $past(done_reg))
    else $error("finished flag not reported or cleared");

  chk_shared_frame_one: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && shared_intensity |=> intensity_frame_o == 3'h0) else $error("shared intensity not frame one");

  chk_gcc_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i |=> global_current_o == $past(global_current_level_reg)) else $error("current level not passed");

  chk_blink_off_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && !blink_enable |=> blink_on_o) else $error("blink toggled while disabled");
endmodule

// File: verification/sync_src_model.sv
`timescale 1ns/1ps
// Cascade master standing on the sync pin; stands still when not running
module sync_src_model #(
  parameter int HALF = 4
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic sync_o
);
  int cnt; // Clocks since last toggle
  ////////////////////////////////////////
  // Idle level at time zero
  initial begin
    sync_o = 1'b0;
    cnt = 0;
  end
  // One toggle per unit, as a master chip gives
  always @(posedge clk_i) begin
    if (run_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) sync_o <= ~sync_o;
    end
  end
endmodule

// File: verification/frame_playback_function_regs_tb.sv
`timescale 1ns/1ps
module frame_playback_function_regs_tb;
  import fpb_pkg::*;
  logic clk_i = 0, rst_i = 1, en_i = 1, reg_wr_i = 0, reg_rd_i = 0, run = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, q, reg_rdata_o, global_current_o;
  logic sync_i, sync_o, sync_oe_o, blink_on_o, audio_mode_o;
  logic [2:0] display_frame_o, intensity_frame_o;
  int n_mismatch = 0, checks = 0, cyc = 0, n;
  // Masks in offset order, from the shared constants
  logic [7:0] wm [6] = '{WMASK_CONFIGURATION, WMASK_PICTURE_FRAME_SELECT, WMASK_PLAYBACK_LOOP_FRAME_COUNT,
    WMASK_PLAYBACK_FRAME_DELAY, WMASK_GLOBAL_CURRENT_LEVEL, WMASK_DISPLAY_OPTIONS};
  // Short units keep the run brief
  frame_playback_function_regs #(.FRAME_UNIT_CYCLES(4), .BLINK_HALF_CYCLES(3)) dut (.clk_i, .rst_i, .en_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sync_i, .sync_o, .sync_oe_o,
    .display_frame_o, .intensity_frame_o, .global_current_o, .blink_on_o, .audio_mode_o);
  sync_src_model #(.HALF(4)) far (.clk_i, .run_i(run), .sync_o(sync_i));
  initial forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////
  // Verdict, reached once
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // One comparison kind; case inequality so X never matches
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Byte write: strobe spans one rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_i);
    reg_wr_i = 0;
  endtask
  // Byte read: answer settled one cycle after the strobe edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1;
    @(negedge clk_i);
    reg_rd_i = 0;
    d = reg_rdata_o;
  endtask
  // Cycles until the displayed frame moves, bounded
  task wait_chg(output int c);
    logic [2:0] f;
    f = display_frame_o;
    c = 0;
    while (display_frame_o === f && c < 400) begin
      @(negedge clk_i);
      c++;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 0;
    for (int i = 0; i < 6; i++) begin
      rd(i[7:0], q);
      chk("reset value", 8'h00, q);
    end
    chk("blink idle", 1, blink_on_o);
    // Reserved bits read back as zero
    for (int i = 0; i < 6; i++) begin
      wr(i[7:0], 8'hFF);
      rd(i[7:0], q);
      chk("write mask", wm[i], q);
    end
    rd(8'h06, q);
    chk("unmapped", 8'h00, q);
    chk("role 11 floats", 0, sync_oe_o);
    chk("audio mode", 1, audio_mode_o);
    chk("shared frame", 0, intensity_frame_o);
    chk("current", 8'hFF, global_current_o);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'hB5);
    wr(8'h01, 8'h07);
    wr(8'h00, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("current", 8'hB5, global_current_o);
    chk("picture frame", 7, display_frame_o);
    chk("own intensity", 7, intensity_frame_o);
    chk("picture mode", 0, audio_mode_o);
    // Enable low: a write strobe is ignored
    en_i = 0;
    wr(8'h04, 8'h11);
    en_i = 1;
    rd(8'h04, q);
    chk("frozen write", 8'hB5, q);
    wr(8'h00, 8'h80);
    chk("slave floats", 0, sync_oe_o);
    // Blink: low phase lasts one half period
    wr(8'h05, 8'h09);
    n = 0;
    while (blink_on_o !== 1'b0 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (blink_on_o === 1'b0 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk("blink half", 3, n);
    wr(8'h05, 8'h00);
    // Finite play as master, then as slave on the far clock
    wr(8'h02, 8'h33);
    wr(8'h03, 8'h01);
    for (int r = 0; r < 2; r++) begin
      run = r[0];
      wr(8'h00, r ? 8'h8B : 8'h4B);
      @(negedge clk_i);
      chk("drive role", !r, sync_oe_o);
      // Master changes the sync level once per unit; slave holds it
      q[0] = sync_o;
      repeat (4) @(negedge clk_i);
      chk("master clock", r ? q[0] : !q[0], sync_o);
      q = 0;
      n = 0;
      while (q[4] !== 1'b1 && n < 300) begin
        rd(8'h07, q);
        n++;
      end
      chk("finish state", 8'h16, q);
      rd(8'h07, q);
      chk("flag cleared", 8'h06, q);
      run = 0;
    end
    // Endless two-frame loop from frame 8, zero hold
    wr(8'h02, 8'h02);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h0F);
    repeat (2) @(negedge clk_i);
    chk("start frame", 7, display_frame_o);
    wait_chg(n);
    chk("wrap", 0, display_frame_o);
    wait_chg(n);
    chk("zero hold", 256, n);
    chk("loop back", 7, display_frame_o);
    complete_run;
  end
endmodule
